/* File: design/udc_pkg.sv */
// Register map, field positions and reset values of the DMA channel control
package udc_pkg;

	localparam logic [7:0] OFF_TX_STAT0 = 8'h00;
	localparam logic [7:0] OFF_TX_STAT1 = 8'h04;
	localparam logic [7:0] OFF_RX_DEF0  = 8'h08;
	localparam logic [7:0] OFF_RX_DEF1  = 8'h0C;
	localparam logic [7:0] OFF_RX_TMO0  = 8'h10;
	localparam logic [7:0] OFF_RX_TMO1  = 8'h14;
	localparam logic [7:0] OFF_TX_CTRL  = 8'h18;

	// Transmit status fields
	localparam int SHORT_PKT_BIT = 0;
	localparam int TX_SEL_BIT    = 4;

	// Receive channel definition fields
	localparam int PTR_LSB   = 0;
	localparam int PTR_W     = 3;
	localparam int GUARD_BIT = 3;
	localparam int SEL_BIT   = 4;
	localparam int CONT_BIT  = 5;
	localparam int IRQE_BIT  = 6;
	localparam int EN_BIT    = 7;

	// Receive time-out fields
	localparam int TMO_FLAG_BIT = 1;
	localparam int TMO_VAL_LSB  = 2;
	localparam int TMO_VAL_W    = 5;
	localparam int TMO_EN_BIT   = 7;

	// Transmit control fields: enables in [1:0], irq enables in [5:4]
	localparam int TX_EN_LSB   = 0;
	localparam int TX_IRQE_LSB = 4;

	localparam logic [7:0] TX_STAT_RESET = 8'h00;
	localparam logic [7:0] RX_DEF_RESET  = 8'h08;
	localparam logic [7:0] RX_TMO_RESET  = 8'h00;
	localparam logic [7:0] TX_CTRL_RESET = 8'h00;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: design/udc_dma_ctrl.sv */
// DMA channel control for two UART transmit and two receive channels
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module udc_dma_ctrl
	import udc_pkg::*;
#(
	parameter int CHANNELS = 2
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        frame_tick,
	input  wire logic [1:0]  tx_short_pkt,
	input  wire logic [1:0]  tx_count_zero,
	input  wire logic [1:0]  rx_byte,
	input  wire logic [1:0]  rx_count_zero,
	input  wire logic [1:0]  rx_error,
	input  wire logic [1:0]  ubm_select,
	output logic [1:0]       tx_enable,
	output logic [1:0]       tx_irq,
	output logic [1:0]       rx_enable,
	output logic [1:0]       rx_buffer_select,
	output logic [5:0]       rx_endpoint_descriptor,
	output logic [1:0]       rx_continuous_mode,
	output logic [1:0]       rx_desc_update,
	output logic [1:0]       rx_irq,
	output logic             in_buffer_select,
	output logic             out_buffer_select
);

	if (CHANNELS != 2) begin : g_chk
		$error("udc_dma_ctrl serves exactly two channels per direction");
	end
	////////////////////////////////////////////////////////////////////////////////
	// Register storage
	logic [7:0]  tx_stat_reg [2];
	logic [7:0]  rx_def_reg [2];
	logic [7:0]  rx_tmo_reg [2];
	logic [7:0]  tx_ctrl_reg;
	logic [4:0]  tmo_cnt_reg [2];
	logic [1:0]  started_reg;
	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	logic        aw_full_reg;
	logic        w_full_reg;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        wr_fire;
	logic        wr_hit;
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= OFF_TX_CTRL);
	endfunction
	assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
	assign wr_hit  = wr_fire && w_strb_reg[0];
	function automatic logic wr_at(input logic [7:0] off, input logic hit,
			input logic [7:0] a);
		wr_at = hit && (a == off);
	endfunction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg   <= 1'b0;
			aw_addr_reg   <= 8'h00;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_reg   <= 1'b1;
			aw_addr_reg   <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (wr_fire) begin
			aw_full_reg <= 1'b0;
		end else begin
			s_axi_awready <= !aw_full_reg && !s_axi_bvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_reg   <= 1'b0;
			w_data_reg   <= 32'h0000_0000;
			w_strb_reg   <= 4'h0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_reg   <= 1'b1;
			w_data_reg   <= s_axi_wdata;
			w_strb_reg   <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (wr_fire) begin
			w_full_reg <= 1'b0;
		end else begin
			s_axi_wready <= !w_full_reg && !s_axi_bvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
	function automatic logic [7:0] rd_mux(input logic [7:0] a);
		case (a)
			OFF_TX_STAT0: rd_mux = tx_stat_reg[0];
			OFF_TX_STAT1: rd_mux = tx_stat_reg[1];
			OFF_RX_DEF0:  rd_mux = rx_def_reg[0] | 8'h08;
			OFF_RX_DEF1:  rd_mux = rx_def_reg[1] | 8'h08;
			OFF_RX_TMO0:  rd_mux = rx_tmo_reg[0];
			OFF_RX_TMO1:  rd_mux = rx_tmo_reg[1];
			OFF_TX_CTRL:  rd_mux = tx_ctrl_reg;
			default:      rd_mux = 8'h00;
		endcase
	endfunction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h00_0000, rd_mux(s_axi_araddr)};
			s_axi_rresp   <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmit channels
	logic [1:0] tx_en_next;
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			tx_en_next[i] = tx_ctrl_reg[TX_EN_LSB + i];
			if (wr_at(OFF_TX_CTRL, wr_hit, aw_addr_reg)) begin
				tx_en_next[i] = w_data_reg[TX_EN_LSB + i];
			end
			if (tx_ctrl_reg[TX_EN_LSB + i] && tx_count_zero[i]) begin
				tx_en_next[i] = 1'b0;
			end
			// Irq enable off keeps the channel armed for the next packet
			if (tx_ctrl_reg[TX_EN_LSB + i] && tx_short_pkt[i]
					&& tx_ctrl_reg[TX_IRQE_LSB + i]) begin
				tx_en_next[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_ctrl_reg <= TX_CTRL_RESET;
		end else begin
			if (wr_at(OFF_TX_CTRL, wr_hit, aw_addr_reg)) begin
				tx_ctrl_reg <= w_data_reg[7:0] & 8'h33;
			end
			tx_ctrl_reg[TX_EN_LSB +: 2] <= tx_en_next;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_irq <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				tx_irq[i] <= tx_ctrl_reg[TX_EN_LSB + i] && !tx_en_next[i]
					&& tx_ctrl_reg[TX_IRQE_LSB + i];
			end
		end
	end
	// Status: short-packet flag, parallel-port select; rest reads zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_stat_reg[0] <= TX_STAT_RESET;
			tx_stat_reg[1] <= TX_STAT_RESET;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (wr_at(i == 0 ? OFF_TX_STAT0 : OFF_TX_STAT1, wr_hit,
						aw_addr_reg)) begin
					tx_stat_reg[i][TX_SEL_BIT] <= w_data_reg[TX_SEL_BIT];
					if (w_data_reg[SHORT_PKT_BIT]) begin
						tx_stat_reg[i][SHORT_PKT_BIT] <= 1'b0;
					end
				end
				// A short packet in the clearing cycle still lands
				if (tx_ctrl_reg[TX_EN_LSB + i] && tx_short_pkt[i]) begin
					tx_stat_reg[i][SHORT_PKT_BIT] <= 1'b1;
				end
				tx_stat_reg[i][3:1] <= 3'h0;
				tx_stat_reg[i][7:5] <= 3'h0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_enable         <= 2'h0;
			in_buffer_select  <= 1'b0;
			out_buffer_select <= 1'b0;
		end else begin
			tx_enable         <= tx_en_next;
			in_buffer_select  <= tx_stat_reg[0][TX_SEL_BIT];
			out_buffer_select <= tx_stat_reg[1][TX_SEL_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receive time-out counters
	logic [1:0] tmo_evt;
	logic [1:0] rx_en;
	logic [1:0] rx_ine;
	logic [1:0] rx_cont;
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			rx_en[i]   = rx_def_reg[i][EN_BIT];
			rx_ine[i]  = rx_def_reg[i][IRQE_BIT];
			rx_cont[i] = rx_def_reg[i][CONT_BIT];
			// A zero count fires on the first frame; software must avoid it
			tmo_evt[i] = frame_tick && rx_tmo_reg[i][TMO_EN_BIT] && rx_en[i]
				&& started_reg[i] && !rx_byte[i] && (tmo_cnt_reg[i] <= 5'h01);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			started_reg    <= 2'h0;
			tmo_cnt_reg[0] <= 5'h00;
			tmo_cnt_reg[1] <= 5'h00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (!rx_en[i] || tmo_evt[i]) begin
					started_reg[i] <= 1'b0;
				end else if (rx_byte[i]) begin
					started_reg[i] <= 1'b1;
				end
				if (rx_byte[i]) begin
					tmo_cnt_reg[i] <= rx_tmo_reg[i][TMO_VAL_LSB +: TMO_VAL_W];
				end else if (frame_tick && rx_tmo_reg[i][TMO_EN_BIT] && rx_en[i]
						&& started_reg[i] && tmo_cnt_reg[i] != 5'h00) begin
					tmo_cnt_reg[i] <= tmo_cnt_reg[i] - 5'h01;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_tmo_reg[0] <= RX_TMO_RESET;
			rx_tmo_reg[1] <= RX_TMO_RESET;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (wr_at(i == 0 ? OFF_RX_TMO0 : OFF_RX_TMO1, wr_hit,
						aw_addr_reg)) begin
					rx_tmo_reg[i][7:2] <= w_data_reg[7:2];
					if (w_data_reg[TMO_FLAG_BIT]) begin
						rx_tmo_reg[i][TMO_FLAG_BIT] <= 1'b0;
					end
				end
				if (tmo_evt[i]) begin
					rx_tmo_reg[i][TMO_FLAG_BIT] <= 1'b1;
				end
				rx_tmo_reg[i][0] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receive channel definition and halt logic

	logic [1:0] rx_err;
	logic [1:0] rx_halt;
	logic [1:0] rx_en_next;
	logic [1:0] rx_sel_next;
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			rx_err[i] = rx_en[i] && rx_error[i];
			// Without irq enable, errors and time-outs leave the channel running
			rx_halt[i] = (rx_en[i] && rx_count_zero[i] && !rx_cont[i])
				|| ((tmo_evt[i] || rx_err[i]) && rx_ine[i]);
			rx_en_next[i]  = rx_en[i];
			rx_sel_next[i] = rx_def_reg[i][SEL_BIT];
			if (wr_at(i == 0 ? OFF_RX_DEF0 : OFF_RX_DEF1, wr_hit, aw_addr_reg)) begin
				rx_en_next[i] = w_data_reg[EN_BIT];
				if (!w_data_reg[GUARD_BIT]) begin
					rx_sel_next[i] = w_data_reg[SEL_BIT];
				end
			end
			if (rx_halt[i]) begin
				rx_en_next[i] = 1'b0;
			end
			if (rx_cont[i]) begin
				rx_sel_next[i] = ubm_select[i];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_def_reg[0] <= RX_DEF_RESET;
			rx_def_reg[1] <= RX_DEF_RESET;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (wr_at(i == 0 ? OFF_RX_DEF0 : OFF_RX_DEF1, wr_hit,
						aw_addr_reg)) begin
					rx_def_reg[i][PTR_LSB +: PTR_W] <= w_data_reg[2:0];
					rx_def_reg[i][CONT_BIT] <= w_data_reg[CONT_BIT];
					rx_def_reg[i][IRQE_BIT] <= w_data_reg[IRQE_BIT];
				end
				rx_def_reg[i][GUARD_BIT] <= 1'b1;
				rx_def_reg[i][SEL_BIT]   <= rx_sel_next[i];
				rx_def_reg[i][EN_BIT]    <= rx_en_next[i];
			end
		end
	end
	// Error halts are signalled by the serial channel, not here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_irq         <= 2'h0;
			rx_desc_update <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				rx_irq[i] <= rx_en[i] && !rx_en_next[i] && rx_ine[i]
					&& !rx_err[i];
				rx_desc_update[i] <= tmo_evt[i] || rx_err[i]
					|| (rx_en[i] && rx_count_zero[i] && !rx_cont[i]);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_enable              <= 2'h0;
			rx_buffer_select       <= 2'h0;
			rx_endpoint_descriptor <= 6'h00;
			rx_continuous_mode     <= 2'h0;
		end else begin
			rx_enable          <= rx_en_next;
			rx_buffer_select   <= rx_sel_next;
			rx_continuous_mode <= {rx_def_reg[1][CONT_BIT], rx_def_reg[0][CONT_BIT]};
			rx_endpoint_descriptor <= {rx_def_reg[1][PTR_LSB +: PTR_W],
				rx_def_reg[0][PTR_LSB +: PTR_W]};
		end
	end

endmodule // udc_dma_ctrl

/* File: verif/udc_dma_ctrl_checker.sv */
// Port assertions for the DMA channel control
`timescale 1ns/1ps
module udc_dma_ctrl_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        frame_tick,
	input wire logic [1:0]  rx_count_zero,
	input wire logic [1:0]  rx_error,
	input wire logic [1:0]  ubm_select,
	input wire logic [1:0]  tx_enable,
	input wire logic [1:0]  tx_irq,
	input wire logic [1:0]  rx_enable,
	input wire logic [1:0]  rx_buffer_select,
	input wire logic [1:0]  rx_continuous_mode,
	input wire logic [1:0]  rx_irq,
	input wire logic        in_buffer_select
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_burst_end;
		rx_count_zero[0] && rx_enable[0] && !rx_continuous_mode[0];
	endsequence
	// Three samples so a lag of two cycles is tolerated
	sequence s_cont_steady;
		(rx_continuous_mode[0] && $stable(ubm_select[0]))[*3];
	endsequence
	property p_reset_quiet;
		$rose(aresetn) |-> rx_enable == 2'h0 && tx_enable == 2'h0 && !s_axi_bvalid;
	endproperty
	property p_rd_upper;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
	endproperty
	property p_rx_irq;
		rx_irq[0] |=> !rx_enable[0];
	endproperty
	property p_tx_irq;
		tx_irq[0] |=> !tx_enable[0];
	endproperty
	property p_err_quiet;
		rx_error[0] && !frame_tick |=> (!rx_irq[0])[*2];
	endproperty
	property p_burst_stop;
		s_burst_end |-> ##[1:2] !rx_enable[0];
	endproperty
	property p_cont;
		s_cont_steady |-> rx_buffer_select[0] == ubm_select[0];
	endproperty
	property p_pport;
		$changed(in_buffer_select) |-> s_axi_bvalid || $past(s_axi_bvalid);
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("busy after reset");
	a_rd_upper: assert property (p_rd_upper) else $error("rdata high bits");
	a_rx_irq: assert property (p_rx_irq) else $error("rx irq, enable high");
	a_tx_irq: assert property (p_tx_irq) else $error("tx irq, enable high");
	a_err_quiet: assert property (p_err_quiet) else $error("irq on rx error");
	a_burst_stop: assert property (p_burst_stop) else $error("burst not stopped");
	a_cont: assert property (p_cont) else $error("select not following");
	a_pport: assert property (p_pport) else $error("pport select moved");
endmodule // udc_dma_ctrl_checker
bind udc_dma_ctrl udc_dma_ctrl_checker u_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .frame_tick(frame_tick),
	.rx_count_zero(rx_count_zero), .rx_error(rx_error), .ubm_select(ubm_select),
	.tx_enable(tx_enable), .tx_irq(tx_irq), .rx_enable(rx_enable),
	.rx_buffer_select(rx_buffer_select), .rx_continuous_mode(rx_continuous_mode),
	.rx_irq(rx_irq), .in_buffer_select(in_buffer_select)
);

/* File: verif/udc_far_model.sv */
// Buffer manager and UART event model
`timescale 1ns/1ps
module udc_far_model #(
	parameter int FRAME = 20
) (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       ev_go,
	input  wire logic [2:0] ev_code,
	input  wire logic       ev_ch,
	input  wire logic       frame_on,
	output logic            frame_tick,
	output logic [1:0]      tx_short_pkt,
	output logic [1:0]      tx_count_zero,
	output logic [1:0]      rx_byte,
	output logic [1:0]      rx_count_zero,
	output logic [1:0]      rx_error,
	output logic [1:0]      ubm_select
);
	int         frame_cnt;
	logic [1:0] hit;
	assign hit = ev_go ? 2'(1 << ev_ch) : 2'h0;
	////////////////////////////////////////////////
	// Short frame period; a real frame is far too long to simulate
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frame_cnt  <= 0;
			frame_tick <= 1'b0;
			ubm_select <= 2'h0;
		end else begin
			frame_cnt  <= (frame_cnt == FRAME - 1) ? 0 : frame_cnt + 1;
			frame_tick <= frame_on && frame_cnt == FRAME - 1;
			if (frame_cnt == 0)
				ubm_select <= ~ubm_select;
		end
	end
	always_ff @(posedge aclk) begin
		rx_byte       <= ev_code == 3'h0 ? hit : 2'h0;
		rx_count_zero <= ev_code == 3'h1 ? hit : 2'h0;
		rx_error      <= ev_code == 3'h2 ? hit : 2'h0;
		tx_short_pkt  <= ev_code == 3'h3 ? hit : 2'h0;
		tx_count_zero <= ev_code == 3'h4 ? hit : 2'h0;
	end
endmodule // udc_far_model

/* File: verif/uart_dma_channel_control_tb.sv */
// Self-checking bench for the DMA channel control
`timescale 1ns/1ps
module uart_dma_channel_control_tb
	import udc_pkg::*;
;
	localparam int FRAME = 20;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ev_go, ev_ch;
	logic        frame_on, awready, wready, bvalid, arready, rvalid, tick, in_sel, out_sel;
	logic [1:0]  bresp, rresp, r, tsp, tcz, rxb, rcz, rer, usb_buffer_manager, tx_en, tx_irq;
	logic [1:0]  rx_en, rx_sel, rx_cont, rx_upd, rx_irq;
	logic [2:0]  ev_code;
	logic [5:0]  rx_ptr;
	logic [7:0]  awaddr, araddr, d, e, g;
	logic [7:0]  sh [2];
	logic [31:0] wdata, rdata;
	int          fail_count, compares, n_irq, n_tx_irq, n_upd, k, u;

	udc_dma_ctrl dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .frame_tick(tick),
		.tx_short_pkt(tsp), .tx_count_zero(tcz), .rx_byte(rxb), .rx_count_zero(rcz),
		.rx_error(rer), .ubm_select(usb_buffer_manager), .tx_enable(tx_en), .tx_irq(tx_irq),
		.rx_enable(rx_en), .rx_buffer_select(rx_sel), .rx_endpoint_descriptor(rx_ptr),
		.rx_continuous_mode(rx_cont), .rx_desc_update(rx_upd), .rx_irq(rx_irq),
		.in_buffer_select(in_sel), .out_buffer_select(out_sel)
	);
	udc_far_model #(.FRAME(FRAME)) far (
		.aclk(aclk), .aresetn(aresetn), .ev_go(ev_go), .ev_code(ev_code), .ev_ch(ev_ch),
		.frame_on(frame_on), .frame_tick(tick), .tx_short_pkt(tsp), .tx_count_zero(tcz),
		.rx_byte(rxb), .rx_count_zero(rcz), .rx_error(rer), .ubm_select(usb_buffer_manager)
	);
	initial aclk = 1'b0;
	always #20 aclk = ~aclk;
	always @(posedge aclk) begin
		n_irq    <= n_irq + 32'(rx_irq[0]);
		n_tx_irq <= n_tx_irq + 32'(tx_irq[0]);
		n_upd    <= n_upd + 32'(rx_upd[0]);
	end
	////////////////////////////////////////////////
	task automatic tally(input bit ok, input string m);
		compares++;
		if (!ok) begin
			fail_count++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask
	task automatic chk_reg(input logic [7:0] x, input logic [7:0] y, input string m);
		tally(x === y, $sformatf("%s got %h exp %h", m, x, y));
	endtask
	task automatic chk_pin(input logic x, input logic y, input string m);
		tally(x === y, m);
	endtask
	task automatic chk_resp(input logic [1:0] x, input logic [1:0] y, input string m);
		tally(x === y, m);
	endtask
	task automatic chk_cnt(input int x, input int y, input string m);
		tally(x == y, m);
	endtask
	// Waits as long as the slave takes; only the watchdog ends a hang
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] v);
		awaddr  <= a;
		wdata   <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask
	task automatic axi_rd(input logic [7:0] a);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		g = rdata[7:0];
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		axi_wr(a, v);
		chk_resp(r, RESP_OKAY, "write resp");
	endtask
	// One-cycle event from the far side, then time to settle
	task automatic ev(input logic [2:0] c, input logic ch);
		ev_go   <= 1'b1;
		ev_code <= c;
		ev_ch   <= ch;
		@(posedge aclk);
		ev_go <= 1'b0;
		repeat (5) @(posedge aclk);
	endtask
	function automatic logic [7:0] exp_def(input logic [7:0] o, input logic [7:0] v);
		return {v[7:5], v[3] ? o[4] : v[4], 1'b1, v[2:0]};
	endfunction
	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		tally(1'b0, "watchdog");
		close_out();
	end
	////////////////////////////////////////////////
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, ev_go, ev_ch, frame_on} = 8'h00;
		{awaddr, araddr, ev_code, wdata} = '0;
		aresetn = 1'b0;
		sh = '{8'h08, 8'h08};
		void'($urandom(32'h22381693));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 7; i++) begin
			axi_rd(8'(4 * i));
			chk_reg(g, (i == 2 || i == 3) ? 8'h08 : 8'h00, "reset");
		end
		axi_wr(8'h1C, 8'h55);
		chk_resp(r, RESP_SLVERR, "unmapped write");
		axi_rd(8'h09);
		chk_resp(r, RESP_SLVERR, "misaligned read");
		$display("test reset and map done");
		for (int i = 0; i < 6; i++) begin
			d = 8'($urandom);
			wr(8'(4 * i[0]), d);
			axi_rd(8'(4 * i[0]));
			chk_reg(g, d & 8'h10, "tx status");
			chk_pin(i[0] ? out_sel : in_sel, d[4], "pport select");
		end
		for (int i = 0; i < 8; i++) begin
			d = 8'($urandom) & 8'h5F;
			if (i == 0) d[4:3] = 2'b10;
			if (i == 2) d[4:3] = 2'b01;
			e = exp_def(sh[i[0]], d);
			sh[i[0]] = e;
			wr(i[0] ? 8'h0C : 8'h08, d);
			axi_rd(i[0] ? 8'h0C : 8'h08);
			chk_reg(g, e, "rx def");
			chk_reg(8'(i[0] ? rx_ptr[5:3] : rx_ptr[2:0]), 8'(d[2:0]), "pointer");
			chk_pin(rx_sel[i[0]], e[4], "buffer select");
		end
		$display("test registers done");
		wr(8'h18, 8'h01);
		wr(8'h00, 8'h00);
		ev(3'h3, 1'b0);
		axi_rd(8'h00);
		chk_reg(g, 8'h01, "short flag");
		chk_pin(tx_en[0], 1'b1, "tx kept on");
		wr(8'h00, 8'h00);
		axi_rd(8'h00);
		chk_reg(g, 8'h01, "write 0 keeps");
		wr(8'h00, 8'h01);
		axi_rd(8'h00);
		chk_reg(g, 8'h00, "write 1 clears");
		k = n_tx_irq;
		wr(8'h18, 8'h11);
		wr(8'h18, 8'h10);
		chk_cnt(n_tx_irq - k, 1, "tx irq");
		$display("test short packet done");
		wr(8'h08, 8'hC0);
		k = n_irq;
		chk_pin(rx_en[0], 1'b1, "started");
		chk_pin(rx_cont[0], 1'b0, "burst mode out");
		ev(3'h1, 1'b0);
		chk_pin(rx_en[0], 1'b0, "burst stop");
		chk_cnt(n_irq - k, 1, "stop irq");
		for (int ie = 0; ie < 2; ie++) begin
			wr(8'h08, {1'b1, ie[0], 6'h00});
			k = n_irq;
			u = n_upd;
			ev(3'h2, 1'b0);
			chk_pin(rx_en[0], !ie[0], "error halt");
			chk_cnt(n_irq - k, 0, "error irq");
			if (ie == 1) chk_cnt(n_upd - u, 1, "error update");
		end
		$display("test burst done");
		wr(8'h10, 8'h88);
		wr(8'h08, 8'hE0);
		chk_pin(rx_cont[0], 1'b1, "continuous mode out");
		frame_on <= 1'b1;
		k = n_irq;
		u = n_upd;
		repeat (3 * FRAME) @(posedge aclk);
		chk_pin(rx_en[0], 1'b1, "idle before byte");
		ev(3'h0, 1'b0);
		repeat (2 * FRAME + 4) @(posedge aclk);
		chk_pin(rx_en[0], 1'b0, "timeout halt");
		chk_cnt(n_irq - k, 1, "timeout irq");
		chk_cnt(n_upd - u, 1, "timeout update");
		axi_rd(8'h10);
		chk_reg(g, 8'h8A, "timeout flag");
		frame_on <= 1'b0;
		$display("test timeout done");
		close_out();
	end
endmodule // uart_dma_channel_control_tb
